// [hw/flash_rd_pkg.sv]
// shared constants and types of the ddr flash read decoder
`default_nettype none
package flash_rd_pkg;
  localparam int CA_W     = 48;
  localparam int ADDR_W   = 25;
  localparam int HP_W     = 22;
  localparam int WORD_W   = 3;
  localparam int PAGE_LSB = 4;
  localparam int LAT_LSB  = 4;
  localparam int HYB_BIT  = 2;
  localparam int WRAP_LSB = 0;
  // latency code field and its decode
  localparam logic [3:0] LAT_CODE_MAX = 4'h_b;
  localparam logic [4:0] LAT_BASE     = 5'h_05;
  localparam logic [4:0] LAT_RSVD     = 5'h_10;
  // shipped config: latency code 1011, 16-byte wrap, no hybrid
  localparam logic [7:0] NV_CONFIG_SHIPPED = 8'h_b0;
  localparam logic [1:0] WRAP_16B = 2'h_0;
  localparam logic [1:0] WRAP_32B = 2'h_1;
  localparam logic [4:0] WRAP_MASK_16B = 5'h_07;
  localparam logic [4:0] WRAP_MASK_32B = 5'h_0f;
  localparam logic [4:0] WRAP_MASK_64B = 5'h_1f;

  typedef struct packed {
    logic            rd;
    logic            reg_space;
    logic            linear;
    logic [6:0]      rsvd_ext;
    logic [HP_W-1:0] half_page;
    logic [12:0]     rsvd_col;
    logic [WORD_W-1:0] word;
  } ca_t;

  typedef struct packed {
    logic       clk_true;
    logic       clk_inv;
    logic       cs_n;
    logic [7:0] dq;
  } pins_t;

  localparam pins_t PINS_IDLE = '{1'b0, 1'b1, 1'b1, 8'h_00};

  typedef enum logic [2:0] {
    ST_IDLE, ST_CA, ST_LAT, ST_DATA, ST_WAIT, ST_SKIP
  } state_t;
endpackage
`default_nettype wire

// [hw/pin_sync.sv]
// two-flop synchroniser for the bus pins
`default_nettype none
module pin_sync
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire flash_rd_pkg::pins_t  raw,
  output flash_rd_pkg::pins_t       synced
);
  import flash_rd_pkg::*;

  pins_t meta;

  // meta feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta   <= PINS_IDLE;
      synced <= PINS_IDLE;
    end
    else
    begin
      meta   <= raw;
      synced <= meta;
    end
  end
endmodule
`default_nettype wire

// [hw/burst_addr.sv]
// next word address of a wrapped, linear or hybrid burst
`default_nettype none
module burst_addr
(
  input  wire logic [flash_rd_pkg::ADDR_W-1:0] cur,
  input  wire logic                            linear,
  input  wire logic                            hybrid,
  input  wire logic [1:0]                      wrap_sel,
  input  wire logic [4:0]                      wrap_cnt,
  output logic [flash_rd_pkg::ADDR_W-1:0]      next,
  output logic                                 page_cross,
  output logic                                 wrap_end
);
  import flash_rd_pkg::*;

  logic [4:0]        mask;
  logic [ADDR_W-1:0] m;
  logic [ADDR_W-1:0] inc;

  always_comb
  begin
    case (wrap_sel)
      WRAP_16B: mask = WRAP_MASK_16B;
      WRAP_32B: mask = WRAP_MASK_32B;
      default:  mask = WRAP_MASK_64B;
    endcase
    m        = {{(ADDR_W-5){1'b0}}, mask};
    inc      = cur + {{(ADDR_W-1){1'b0}}, 1'b1};
    wrap_end = hybrid && !linear && (wrap_cnt == mask);
    if (linear)
      next = inc;
    else if (wrap_end)
      next = (cur | m) + {{(ADDR_W-1){1'b0}}, 1'b1};
    else
      next = (cur & ~m) | (inc & m);
    // aligned 8/16-word wraps stay inside one page
    page_cross = next[ADDR_W-1:PAGE_LSB] != cur[ADDR_W-1:PAGE_LSB];
  end
endmodule
`default_nettype wire

// [hw/ddr_flash_read_ca_decoder.sv]
// ddr flash bus command decoder and read data engine
// Operation
// - ca bit 47 high means read, low means write
// - ca bit 46 picks space; device ignores it, one space only
// - ca bit 45 low gives wrapped burst, high gives linear
// - half-page address is taken from ca bits 37 to 16
// - ca bits 2 to 0 select starting word in half-page
// - array access starts once first two ca words are captured
// - after latency clocks, strobe and data start together
// - new byte on every strobe edge while host keeps clocking
// - wrapped burst wraps within length; linear runs across pages
// - hybrid: one wrapped burst, then linear from following address
// - chip select high ends a read; device stops driving
// - linear burst past last address rolls over to zero
// - 16/32-byte wraps never cross pages; 64-byte may wait
// - latency code 0000-1011 gives 5-16 clocks, rest reserved
// - shipped configuration selects sixteen latency clocks
// - three ca words over first three clocks, both edges
// - word bits 15-8 on rising edge, 7-0 on falling
// - first page crossing waits latency minus words delivered
`default_nettype none
module ddr_flash_read_ca_decoder
(
  input  wire logic                            clk,
  input  wire logic                            rst,
  input  wire logic                            bus_clock_true,
  input  wire logic                            bus_clock_inverted,
  input  wire logic                            chip_select_n,
  input  wire logic [7:0]                      dq_in,
  output logic [7:0]                           dq_out,
  output logic                                 dq_oe,
  output logic                                 read_data_strobe,
  output logic                                 read_data_strobe_oe,
  input  wire logic                            config_wr,
  input  wire logic [7:0]                      config_wdata,
  output logic [7:0]                           active_config,
  output logic                                 array_start,
  output logic [flash_rd_pkg::ADDR_W-1:0]      array_addr,
  input  wire logic [15:0]                     array_data,
  output flash_rd_pkg::ca_t                    cmd_addr,
  output logic                                 busy
);
  import flash_rd_pkg::*;

  pins_t             raw;
  pins_t             pins;
  state_t            state;
  state_t            next_state;
  logic [5:0]        edge_cnt;
  logic [5:0]        next_edge_cnt;
  logic [2:0]        byte_cnt;
  logic [2:0]        next_byte_cnt;
  ca_t               next_cmd_addr;
  logic [ADDR_W-1:0] next_array_addr;
  logic              next_array_start;
  logic [7:0]        lo_byte;
  logic [7:0]        next_lo_byte;
  logic [7:0]        next_dq_out;
  logic              next_dq_oe;
  logic              next_strobe;
  logic              next_strobe_oe;
  logic [5:0]        words_cnt;
  logic [5:0]        next_words_cnt;
  logic [4:0]        wrap_cnt;
  logic [4:0]        next_wrap_cnt;
  logic [4:0]        wait_cnt;
  logic [4:0]        next_wait_cnt;
  logic              crossed_once;
  logic              next_crossed_once;
  logic              hyb_done;
  logic              next_hyb_done;
  logic [7:0]        next_active_config;
  logic              prev_clk;
  logic              rise;
  logic              fall;
  logic              do_rise;
  logic              do_fall;
  logic [3:0]        lat_code;
  logic [4:0]        lat;
  logic              lin_mode;
  logic [ADDR_W-1:0] addr_next;
  logic              page_cross;
  logic              wrap_end;

  assign raw = '{bus_clock_true, bus_clock_inverted, chip_select_n, dq_in};

  pin_sync u_sync
  (
    .clk    (clk),
    .rst    (rst),
    .raw    (raw),
    .synced (pins)
  );

  // edges of the sampled bus clock; 160 ns period gives ~4 samples each
  assign rise = pins.clk_true && !prev_clk;
  assign fall = !pins.clk_true && prev_clk;

  // reserved codes fall back to the slowest, safest latency
  assign lat_code = active_config[LAT_LSB+3:LAT_LSB];
  assign lat = (lat_code > LAT_CODE_MAX) ? LAT_RSVD
               : LAT_BASE + {1'b0, lat_code};
  assign lin_mode = cmd_addr.linear || hyb_done;
  assign busy = (state != ST_IDLE);

  burst_addr u_addr
  (
    .cur        (array_addr),
    .linear     (lin_mode),
    .hybrid     (active_config[HYB_BIT]),
    .wrap_sel   (active_config[WRAP_LSB+1:WRAP_LSB]),
    .wrap_cnt   (wrap_cnt),
    .next       (addr_next),
    .page_cross (page_cross),
    .wrap_end   (wrap_end)
  );

  always_comb
  begin
    next_state         = state;
    next_edge_cnt      = edge_cnt;
    next_byte_cnt      = byte_cnt;
    next_cmd_addr      = cmd_addr;
    next_array_addr    = array_addr;
    next_array_start   = 1'b0;
    next_lo_byte       = lo_byte;
    next_dq_out        = dq_out;
    next_dq_oe         = dq_oe;
    next_strobe        = read_data_strobe;
    next_strobe_oe     = read_data_strobe_oe;
    next_words_cnt     = words_cnt;
    next_wrap_cnt      = wrap_cnt;
    next_wait_cnt      = wait_cnt;
    next_crossed_once  = crossed_once;
    next_hyb_done      = hyb_done;
    next_active_config = active_config;
    do_rise            = 1'b0;
    do_fall            = 1'b0;
    if (config_wr)
      next_active_config = config_wdata;
    if (rise && edge_cnt != 6'h_3f)
      next_edge_cnt = edge_cnt + 6'h_01;
    case (state)
      ST_IDLE:
      begin
        // a frame opening with the clock high is not a legal start
        if (!pins.cs_n && !pins.clk_true && pins.clk_inv)
        begin
          next_state        = ST_CA;
          next_edge_cnt     = 6'h_00;
          next_byte_cnt     = 3'h_0;
          next_cmd_addr     = '0;
          next_words_cnt    = 6'h_00;
          next_wrap_cnt     = 5'h_00;
          next_crossed_once = 1'b0;
          next_hyb_done     = 1'b0;
        end
        else if (!pins.cs_n)
          next_state = ST_SKIP;
      end
      ST_CA:
      begin
        if (rise || fall)
        begin
          // host keeps high byte on rise, low byte on fall
          next_cmd_addr[CA_W-1-8*byte_cnt -: 8] = pins.dq;
          next_byte_cnt = byte_cnt + 3'h_1;
          if (byte_cnt == 3'h_3 && next_cmd_addr.rd)
          begin
            next_array_start = 1'b1;
            next_array_addr  = {next_cmd_addr.half_page, 3'h_0};
          end
          if (byte_cnt == 3'h_5)
          begin
            // space bit is not decoded: one address space
            next_array_addr = {next_cmd_addr.half_page,
                               next_cmd_addr.word};
            next_state = next_cmd_addr.rd ? ST_LAT : ST_SKIP;
            next_strobe_oe = next_cmd_addr.rd;
          end
        end
      end
      ST_LAT:
      begin
        if (rise && edge_cnt == {1'b0, lat} + 6'h_01)
          do_rise = 1'b1;
      end
      ST_DATA:
      begin
        do_rise = rise;
        do_fall = fall;
      end
      ST_WAIT:
      begin
        if (rise)
        begin
          if (wait_cnt == 5'h_00)
            do_rise = 1'b1;
          else
            next_wait_cnt = wait_cnt - 5'h_01;
        end
      end
      ST_SKIP:
      begin
        next_state = ST_SKIP;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
    if (do_rise)
    begin
      next_state   = ST_DATA;
      next_dq_out  = array_data[15:8];
      next_lo_byte = array_data[7:0];
      next_strobe  = 1'b1;
      next_dq_oe   = 1'b1;
    end
    if (do_fall)
    begin
      next_dq_out     = lo_byte;
      next_strobe     = 1'b0;
      next_array_addr = addr_next;
      if (!hyb_done)
        next_wrap_cnt = wrap_cnt + 5'h_01;
      if (wrap_end)
        next_hyb_done = 1'b1;
      if (!crossed_once)
        next_words_cnt = words_cnt + 6'h_01;
      if (page_cross && !crossed_once)
      begin
        next_crossed_once = 1'b1;
        if ({1'b0, lat} > words_cnt + 6'h_01)
        begin
          next_wait_cnt = 5'({1'b0, lat} - words_cnt - 6'h_01);
          next_state    = ST_WAIT;
        end
      end
    end
    // chip select high ends any frame and releases the pins
    if (pins.cs_n)
    begin
      next_state     = ST_IDLE;
      next_dq_oe     = 1'b0;
      next_strobe    = 1'b0;
      next_strobe_oe = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state               <= ST_IDLE;
      edge_cnt            <= 6'h_00;
      byte_cnt            <= 3'h_0;
      cmd_addr            <= '0;
      array_addr          <= '0;
      array_start         <= 1'b0;
      lo_byte             <= 8'h_00;
      dq_out              <= 8'h_00;
      dq_oe               <= 1'b0;
      read_data_strobe    <= 1'b0;
      read_data_strobe_oe <= 1'b0;
      words_cnt           <= 6'h_00;
      wrap_cnt            <= 5'h_00;
      wait_cnt            <= 5'h_00;
      crossed_once        <= 1'b0;
      hyb_done            <= 1'b0;
      active_config       <= NV_CONFIG_SHIPPED;
      prev_clk            <= 1'b0;
    end
    else
    begin
      state               <= next_state;
      edge_cnt            <= next_edge_cnt;
      byte_cnt            <= next_byte_cnt;
      cmd_addr            <= next_cmd_addr;
      array_addr          <= next_array_addr;
      array_start         <= next_array_start;
      lo_byte             <= next_lo_byte;
      dq_out              <= next_dq_out;
      dq_oe               <= next_dq_oe;
      read_data_strobe    <= next_strobe;
      read_data_strobe_oe <= next_strobe_oe;
      words_cnt           <= next_words_cnt;
      wrap_cnt            <= next_wrap_cnt;
      wait_cnt            <= next_wait_cnt;
      crossed_once        <= next_crossed_once;
      hyb_done            <= next_hyb_done;
      active_config       <= next_active_config;
      prev_clk            <= pins.clk_true;
    end
  end

  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_cs_release: assert property (
    pins.cs_n |=> !dq_oe && !read_data_strobe_oe)
    else $error("pins still driven after chip select high");

  chk_write_quiet: assert property (
    state == ST_SKIP |-> !dq_oe && !read_data_strobe_oe)
    else $error("write frame drives the bus");

  chk_array_early: assert property (
    array_start |-> state == ST_CA && byte_cnt == 3'h_4 && cmd_addr.rd
                    && array_addr[2:0] == 3'h_0)
    else $error("array access not started after second ca word");

  chk_first_data: assert property (
    (state == ST_LAT && rise && !pins.cs_n) |=>
    ((state == ST_DATA) ==
     ($past(edge_cnt) == {1'b0, $past(lat)} + 6'h_01)))
    else $error("first data not at end of latency");

  chk_strobe_rise: assert property (
    (do_rise && !pins.cs_n) |=> read_data_strobe && dq_oe
    && {dq_out, 8'h_00} == ($past(array_data) & 16'h_ff00))
    else $error("rising strobe without high byte");

  chk_strobe_fall: assert property (
    (do_fall && !pins.cs_n) |=> !read_data_strobe
                                && dq_out == $past(lo_byte))
    else $error("falling strobe without low byte");

  chk_wait_hold: assert property (
    (state == ST_WAIT && $past(state) == ST_WAIT) |->
    $stable(read_data_strobe) && $stable(dq_out))
    else $error("strobe moved during crossing wait");

  chk_cross_wait: assert property (
    (do_fall && page_cross && !crossed_once && !pins.cs_n
     && {1'b0, lat} > words_cnt + 6'h_01) |=>
    state == ST_WAIT
    && wait_cnt == 5'({1'b0, $past(lat)} - $past(words_cnt) - 6'h_01))
    else $error("crossing wait count wrong");

  chk_rollover: assert property (
    (do_fall && lin_mode && array_addr == '1) |=> array_addr == '0)
    else $error("linear burst did not roll over");

  chk_wrap_stays: assert property (
    (do_fall && !lin_mode && !wrap_end) |=>
    $stable(array_addr[ADDR_W-1:5]))
    else $error("wrapped burst left its block");

  chk_ship_latency: assert property (
    $fell(rst) |-> lat == 5'h_10)
    else $error("shipped latency not sixteen clocks");
endmodule
`default_nettype wire

// [verification/host_bus_model.sv]
// host bus controller model: bus clock, chip select and ca bytes
`default_nettype none
module host_bus_model
(
  input  wire logic  clk,
  output logic       ck,
  output logic       ck_n,
  output logic       cs_n,
  output logic [7:0] dq
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    ck = 1'b0;
    ck_n = 1'b1;
    cs_n = 1'b1;
    dq = 8'h_00;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // half period of four clk: far below any latency code limit
  task automatic frame(input logic [47:0] ca, input int rises,
                       input bit bad);
    ck = bad;
    ck_n = ~bad;
    w(2);
    cs_n = 1'b0;
    w(4);
    for (int e = 0; e < 2 * rises; e++)
    begin
      // released bus shows the inverse, never a stale byte
      dq = (e < 6) ? ca[47 - 8 * e -: 8] : ~dq;
      w(2);
      ck = ~ck;
      ck_n = ~ck_n;
      w(2);
    end
    ck = 1'b0;
    ck_n = 1'b1;
    w(4);
    cs_n = 1'b1;
    w(8);
  endtask
endmodule
`default_nettype wire

// [verification/ddr_flash_read_ca_decoder_tb_top.sv]
// self-checking bench of the ddr flash read decoder
`default_nettype none
module ddr_flash_read_ca_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_rd_pkg::*;
  logic              clk;
  logic              rst;
  logic              ck;
  logic              ck_n;
  logic              cs_n;
  logic [7:0]        dq_in;
  logic [7:0]        dq_out;
  logic              dq_oe;
  logic              rds;
  logic              rds_oe;
  logic              config_wr;
  logic [7:0]        config_wdata;
  logic [7:0]        active_config;
  logic              array_start;
  logic [ADDR_W-1:0] array_addr;
  logic [15:0]       array_data;
  ca_t               cmd_addr;
  logic              busy;
  logic [7:0]        exp_q[$];
  logic [ADDR_W-1:0] exp_base;
  logic              prev_rds;
  int                mismatches, tests_run, rx, starts, cycles;
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // neighbouring words always differ in the high byte
  function automatic logic [15:0] arr(input logic [ADDR_W-1:0] a);
    return {a[7:0], a[15:8]} ^ 16'h_5a3c;
  endfunction
  assign array_data = arr(array_addr);
  ddr_flash_read_ca_decoder ddr_flash_read_ca_decoder_i
  (
    .clk                 (clk),
    .rst                 (rst),
    .bus_clock_true      (ck),
    .bus_clock_inverted  (ck_n),
    .chip_select_n       (cs_n),
    .dq_in               (dq_in),
    .dq_out              (dq_out),
    .dq_oe               (dq_oe),
    .read_data_strobe    (rds),
    .read_data_strobe_oe (rds_oe),
    .config_wr           (config_wr),
    .config_wdata        (config_wdata),
    .active_config       (active_config),
    .array_start         (array_start),
    .array_addr          (array_addr),
    .array_data          (array_data),
    .cmd_addr            (cmd_addr),
    .busy                (busy)
  );
  host_bus_model host_bus_model_i
  (
    .clk  (clk),
    .ck   (ck),
    .ck_n (ck_n),
    .cs_n (cs_n),
    .dq   (dq_in)
  );
  task automatic check(input logic [47:0] seen, input logic [47:0] exp,
                       input string what);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // sampled on the falling clk edge, where outputs have settled
  always @(negedge clk)
  begin
    if (dq_oe === 1'b1 && rds !== prev_rds)
    begin
      rx++;
      check(rds_oe, 1, "strobe enable");
      if (exp_q.size() > 0)
        check(dq_out, exp_q.pop_front(), "read byte");
      else
        check(1, 0, "byte beyond burst");
    end
    if (array_start === 1'b1)
    begin
      starts++;
      check(array_addr, exp_base, "array start address");
    end
    prev_rds = rds;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 40000)
    begin
      mismatches++;
      $display("Error at %0t: run timed out", $time);
      finish_test();
    end
  end
  task automatic read_frame(input logic [3:0] code, input bit hyb,
    input logic [1:0] ws, input bit lin, input logic [ADDR_W-1:0] st,
    input int n, input bit wc, input bit rd, input bit sp, input bit bad);
    int                lat;
    int                wl;
    int                wt;
    logic [ADDR_W-1:0] seq[64];
    logic [ADDR_W-1:0] a;
    logic [ADDR_W-1:0] base;
    logic [47:0]       ca;
    logic [15:0]       d;
    if (wc)
    begin
      config_wdata = {code, 1'b0, hyb, ws};
      config_wr = 1'b1;
      host_bus_model_i.w(1);
      config_wr = 1'b0;
      check(active_config, {code, 1'b0, hyb, ws}, "config");
    end
    // reserved codes settle as the longest latency
    lat = (code <= LAT_CODE_MAX) ? code + 5 : 16;
    wl = (ws == WRAP_16B) ? 8 : (ws == WRAP_32B) ? 16 : 32;
    base = st & ~ADDR_W'(wl - 1);
    a = st;
    wt = 0;
    for (int k = 0; k < 64; k++)
    begin
      seq[k] = a;
      if (lin || (hyb && k >= wl - 1))
        a = (!lin && k == wl - 1) ? base + ADDR_W'(wl) : a + 1;
      else
        a = base | ((a + 1) & ADDR_W'(wl - 1));
    end
    for (int k = 62; k >= 0; k--)
      if (seq[k + 1][24:4] != seq[k][24:4] && k + 1 < n)
        wt = lat - (k + 1);
    if (wt < 0)
      wt = 0;
    ca = {rd, sp, lin, 7'h_00, st[24:3], 13'h_0000, st[2:0]};
    exp_base = {st[24:3], 3'b000};
    for (int k = 0; k < n - wt; k++)
    begin
      d = arr(seq[k]);
      if (rd && !bad)
      begin
        exp_q.push_back(d[15:8]);
        exp_q.push_back(d[7:0]);
      end
    end
    rx = 0;
    starts = 0;
    host_bus_model_i.frame(ca, lat + 1 + n, bad);
    check(rx, (rd && !bad) ? 2 * (n - wt) : 0, "bytes");
    check(starts, rd && !bad, "array starts");
    check(exp_q.size(), 0, "bytes missing");
    check({dq_oe, rds_oe, busy}, 0, "released after select");
    if (!bad)
      check(cmd_addr, ca, "captured ca");
    exp_q.delete();
  endtask
  initial
  begin
    logic [1:0] wsel[5] = '{2'h_0, 2'h_1, 2'h_2, 2'h_0, 2'h_3};
    int         off[5] = '{5, 13, 17, 5, 9};
    rst = 1'b1;
    config_wr = 1'b0;
    config_wdata = 8'h_00;
    {mismatches, tests_run, rx, starts, cycles} = '0;
    prev_rds = 1'b0;
    exp_base = '0;
    void'($urandom(4377));
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    host_bus_model_i.w(4);
    check(active_config[7:4], 4'h_b, "shipped latency code");
    check({dq_oe, rds_oe, busy}, 0, "idle after reset");
    read_frame(4'h_b, 0, 2'h_0, 1, ADDR_W'($urandom), 20, 0, 1, 0, 0);
    for (int c = 0; c < 16; c++)
      read_frame(c[3:0], 0, 2'($urandom), 1, ADDR_W'($urandom), 20, 1, 1, 0,
                 0);
    for (int i = 0; i < 5; i++)
      read_frame(4'h_b, i > 2, wsel[i], 0,
                 (ADDR_W'($urandom) & ~ADDR_W'(31)) | ADDR_W'(off[i]), 20,
                 1, 1, 0, 0);
    // fourth-last word of the array, register space bit set
    read_frame(4'h_3, 0, 2'h_0, 1, 25'h_1ff_fffc, 20, 1, 1, 1, 0);
    // read cut short after three words
    read_frame(4'h_0, 0, 2'h_0, 1, 25'h_000_0040, 3, 1, 1, 0, 0);
    // write frame, then a start with the clock high
    read_frame(4'h_0, 0, 2'h_0, 1, ADDR_W'($urandom), 4, 0, 0, 0, 0);
    read_frame(4'h_0, 0, 2'h_0, 1, ADDR_W'($urandom), 4, 0, 1, 0, 1);
    finish_test();
  end
endmodule
`default_nettype wire
